// ### core/sfp_defs.svh
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// ==========================================================
// instruction codes
`define SFP_OP_UNLOCK 8'h06
`define SFP_OP_LOCK 8'h04
`define SFP_OP_STAT_RD 8'h05
`define SFP_OP_STAT_WR 8'h01
`define SFP_OP_PAGE_WR 8'h02
`define SFP_OP_BLK_CLR 8'hD8
`define SFP_OP_ALL_CLR 8'hC7
`define SFP_OP_SLEEP 8'hB9
`define SFP_OP_WAKE 8'hAB

// ==========================================================
// frame bit counts
`define SFP_CNT_OP 12'h008
`define SFP_CNT_STAT_WR 12'h010
`define SFP_CNT_ADDR 12'h020
`define SFP_CNT_PAGE 12'h028
`define SFP_CNT_MAX 12'hFFF
`define SFP_CAP_A15 12'h010
`define SFP_BIT_IN_BYTE 2:0

// ==========================================================
// status byte layout
`define SFP_SR_LOCK 7
`define SFP_SR_HI 3
`define SFP_SR_LO 2
`define SFP_SR_LATCH 1
`define SFP_SR_BUSY 0

// ==========================================================
// register map
`define SFP_ADR_CTRL 8'h00
`define SFP_ADR_STAT 8'h04
`define SFP_ADR_LAST 8'h08
`define SFP_CTRL_SUPPLY 0
`define SFP_RST_SUPPLY 1'b1

// ==========================================================
// timing
`define SFP_CLK_NS 5
`define SFP_PUW_NS 10000
`define SFP_PUW_CYC (16'((`SFP_PUW_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS))
`define SFP_WCYC_NS 2000
`define SFP_WCYC_CYC (16'(`SFP_WCYC_NS / `SFP_CLK_NS))

`endif

// ### core/sfp_pkg.sv
package sfp_pkg;

    // ==========================================================
    // pin group
    typedef struct packed {
        logic sck;
        logic selN;
        logic mosi;
        logic pauseN;
        logic protectN;
    } sfp_pin_t;

    // ==========================================================
    // whole block state
    typedef struct packed {
        sfp_pin_t syncA;
        sfp_pin_t syncB;
        logic sckPrev;
        logic selPrev;
        logic paused;
        logic [7:0] shift;
        logic [11:0] bitCnt;
        logic [7:0] opcode;
        logic [7:0] statData;
        logic addrHi;
        logic latch;
        logic lockBit;
        logic areaHi;
        logic areaLo;
        logic busy;
        logic [15:0] busyCnt;
        logic dpd;
        logic [15:0] puwCnt;
        logic puwDone;
        logic supplyOk;
        logic [7:0] lastOp;
        logic lastRej;
        logic miso;
        logic oe;
        logic ack;
        logic [31:0] rdat;
    } sfp_state_t;

endpackage

// ### core/sfp_flash_guard.sv
`timescale 1ns/1ps
`include "sfp_defs.svh"

module sfp_flash_guard
    import sfp_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // flash pins
    input wire sfp_pin_t pinIn,
    output logic misoOut,
    output logic misoOe,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic wbAck,
    output logic [31:0] wbDatO
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] statusByte(input sfp_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[`SFP_SR_LOCK] = s.lockBit;
        b[`SFP_SR_HI] = s.areaHi;
        b[`SFP_SR_LO] = s.areaLo;
        b[`SFP_SR_LATCH] = s.latch;
        b[`SFP_SR_BUSY] = s.busy;
        return b;
    endfunction

    function automatic logic onByte(input logic [11:0] cnt);
        return cnt[`SFP_BIT_IN_BYTE] == 3'h0;
    endfunction

    // ==========================================================
    // state
    sfp_state_t st;
    sfp_state_t nxt;
    logic selected;
    logic sckRise;
    logic sckFall;
    logic selRise;
    logic hardNow;
    logic writeOk;
    logic protBlk;
    logic accept;
    logic isMod;
    logic [7:0] newShift;
    logic [7:0] sb;

    // only the second sync stage is looked at
    assign selected = !st.syncB.selN;
    assign sckRise = st.syncB.sck && !st.sckPrev;
    assign sckFall = !st.syncB.sck && st.sckPrev;
    assign selRise = st.syncB.selN && !st.selPrev;
    assign hardNow = st.lockBit && !st.syncB.protectN;
    assign writeOk = st.puwDone && st.supplyOk;
    assign protBlk = st.areaHi && st.areaLo;
    assign newShift = {st.shift[6:0], st.syncB.mosi};
    assign sb = statusByte(st);

    // ==========================================================
    // next state
    always_comb
    begin
        accept = 1'b0;
        isMod = 1'b0;
        nxt = st;
        nxt.syncA = pinIn;
        nxt.syncB = st.syncA;
        // edges tracked even when paused, so no false edge at resume
        nxt.sckPrev = st.syncB.sck;
        nxt.selPrev = st.syncB.selN;

        // power-up write delay
        if (!st.puwDone)
        begin
            nxt.puwCnt = st.puwCnt + 16'h1;
            if (st.puwCnt == `SFP_PUW_CYC - 16'h1)
            begin
                nxt.puwDone = 1'b1;
            end
        end

        // internal cycle runs regardless of pause
        if (st.busy)
        begin
            if (st.busyCnt == 16'h0)
            begin
                nxt.busy = 1'b0;
            end
            else
            begin
                nxt.busyCnt = st.busyCnt - 16'h1;
            end
        end

        // pause follows its pin only while clock is low
        if (selected)
        begin
            if (!st.syncB.sck)
            begin
                nxt.paused = !st.syncB.pauseN;
            end
        end
        else
        begin
            nxt.paused = 1'b0;
        end

        // serial shift, frozen while paused
        if (selected && !st.paused)
        begin
            if (sckRise)
            begin
                nxt.shift = newShift;
                if (st.bitCnt != `SFP_CNT_MAX)
                begin
                    nxt.bitCnt = st.bitCnt + 12'h1;
                end
                if (st.bitCnt == `SFP_CNT_OP - 12'h1)
                begin
                    nxt.opcode = newShift;
                end
                if (st.bitCnt == `SFP_CNT_STAT_WR - 12'h1)
                begin
                    nxt.statData = newShift;
                end
                if (st.bitCnt == `SFP_CAP_A15)
                begin
                    nxt.addrHi = st.syncB.mosi;
                end
            end
            if (sckFall && st.opcode == `SFP_OP_STAT_RD && st.bitCnt >= `SFP_CNT_OP)
            begin
                nxt.miso = sb[~st.bitCnt[`SFP_BIT_IN_BYTE]];
            end
        end

        // end of frame: decide, then clear the interface
        if (selRise)
        begin
            if (!st.paused && st.bitCnt >= `SFP_CNT_OP)
            begin
                nxt.lastOp = st.opcode;
                if (st.dpd)
                begin
                    if (st.opcode == `SFP_OP_WAKE)
                    begin
                        nxt.dpd = 1'b0;
                    end
                end
                else if (!st.busy)
                begin
                    case (st.opcode)
                        `SFP_OP_UNLOCK:
                        begin
                            nxt.latch = 1'b1;
                        end
                        `SFP_OP_LOCK:
                        begin
                            nxt.latch = 1'b0;
                        end
                        `SFP_OP_SLEEP:
                        begin
                            nxt.dpd = 1'b1;
                        end
                        `SFP_OP_STAT_WR:
                        begin
                            isMod = 1'b1;
                            accept = onByte(st.bitCnt) && st.bitCnt >= `SFP_CNT_STAT_WR && !hardNow;
                        end
                        `SFP_OP_PAGE_WR:
                        begin
                            isMod = 1'b1;
                            accept = onByte(st.bitCnt) && st.bitCnt >= `SFP_CNT_PAGE && !protBlk;
                        end
                        `SFP_OP_BLK_CLR:
                        begin
                            isMod = 1'b1;
                            accept = onByte(st.bitCnt) && st.bitCnt == `SFP_CNT_ADDR && !protBlk;
                        end
                        `SFP_OP_ALL_CLR:
                        begin
                            isMod = 1'b1;
                            accept = st.bitCnt == `SFP_CNT_OP && !st.areaHi && !st.areaLo;
                        end
                        default:
                        begin
                        end
                    endcase
                    if (isMod)
                    begin
                        if (accept && st.latch && writeOk)
                        begin
                            nxt.busy = 1'b1;
                            nxt.busyCnt = `SFP_WCYC_CYC;
                            nxt.latch = 1'b0;
                            nxt.lastRej = 1'b0;
                            if (st.opcode == `SFP_OP_STAT_WR)
                            begin
                                nxt.lockBit = st.statData[`SFP_SR_LOCK];
                                nxt.areaHi = st.statData[`SFP_SR_HI];
                                nxt.areaLo = st.statData[`SFP_SR_LO];
                            end
                        end
                        else
                        begin
                            nxt.lastRej = 1'b1;
                        end
                    end
                end
            end
            nxt.bitCnt = 12'h000;
            nxt.shift = 8'h00;
            nxt.opcode = 8'h00;
        end

        // output driven only for a live status read
        nxt.oe = selected && !nxt.paused && !st.dpd && st.opcode == `SFP_OP_STAT_RD
            && st.bitCnt >= `SFP_CNT_OP;

        // wishbone: one-cycle ack, then low
        nxt.ack = wbCyc && wbStb && !st.ack;
        if (wbCyc && wbStb && !st.ack)
        begin
            if (wbWe && wbAdr == `SFP_ADR_CTRL && wbSel[0])
            begin
                nxt.supplyOk = wbDatI[`SFP_CTRL_SUPPLY];
            end
            case (wbAdr)
                `SFP_ADR_CTRL: nxt.rdat = {31'h0, st.supplyOk};
                `SFP_ADR_STAT: nxt.rdat = {20'h0, hardNow, st.puwDone, st.dpd, st.paused, sb};
                `SFP_ADR_LAST: nxt.rdat = {22'h0, st.lastRej, st.addrHi, st.lastOp};
                default: nxt.rdat = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // registers; lock and area bits start clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.syncA.selN <= 1'b1;
            st.syncA.pauseN <= 1'b1;
            st.syncA.protectN <= 1'b1;
            st.syncB.selN <= 1'b1;
            st.syncB.pauseN <= 1'b1;
            st.syncB.protectN <= 1'b1;
            st.selPrev <= 1'b1;
            st.supplyOk <= `SFP_RST_SUPPLY;
        end
        else if (clkEn)
        begin
            st <= nxt;
        end
    end

    assign misoOut = st.miso;
    assign misoOe = st.oe;
    assign wbAck = st.ack;
    assign wbDatO = st.rdat;

    // ==========================================================
    // checks
    property p_pause_quiet;
        @(posedge clk) disable iff (!rstn)
        st.paused |-> !misoOe;
    endproperty
    a_pause_quiet: assert property (p_pause_quiet) else $error("output driven while paused");

    property p_pause_freeze;
        @(posedge clk) disable iff (!rstn)
        (st.paused && $past(st.paused) && !st.syncB.selN) |-> ($stable(st.bitCnt) && $stable(st.shift));
    endproperty
    a_pause_freeze: assert property (p_pause_freeze) else $error("shift state moved during pause");

    property p_pause_clk_low;
        @(posedge clk) disable iff (!rstn)
        ($changed(st.paused) && $past(!st.syncB.selN)) |-> $past(!st.syncB.sck);
    endproperty
    a_pause_clk_low: assert property (p_pause_clk_low) else $error("pause changed with clock high");

    property p_start_latch;
        @(posedge clk) disable iff (!rstn)
        $rose(st.busy) |-> ($past(st.latch) && !st.latch);
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("write latch wrong at cycle start");

    property p_start_byte;
        @(posedge clk) disable iff (!rstn)
        $rose(st.busy) |-> ($past(st.bitCnt[`SFP_BIT_IN_BYTE]) == 3'h0);
    endproperty
    a_start_byte: assert property (p_start_byte) else $error("cycle started off a byte boundary");

    property p_start_puw;
        @(posedge clk) disable iff (!rstn)
        $rose(st.busy) |-> ($past(st.puwDone) && $past(st.supplyOk));
    endproperty
    a_start_puw: assert property (p_start_puw) else $error("cycle started before power-up delay");

    property p_sleep_only_wake;
        @(posedge clk) disable iff (!rstn)
        $rose(st.busy) |-> !$past(st.dpd);
    endproperty
    a_sleep_only_wake: assert property (p_sleep_only_wake) else $error("cycle started in deep power-down");

    property p_hard_refuse;
        @(posedge clk) disable iff (!rstn)
        $past(hardNow) && !$past(st.busy) |-> ($stable(st.lockBit) && $stable(st.areaHi) && $stable(st.areaLo));
    endproperty
    a_hard_refuse: assert property (p_hard_refuse) else $error("status bits changed in hard guard");

    property p_all_clear;
        @(posedge clk) disable iff (!rstn)
        ($rose(st.busy) && st.lastOp == `SFP_OP_ALL_CLR) |-> ($past(!st.areaHi) && $past(!st.areaLo));
    endproperty
    a_all_clear: assert property (p_all_clear) else $error("whole clear ran with area guard set");

    property p_busy_no_change;
        @(posedge clk) disable iff (!rstn)
        ($past(st.busy) && st.busy) |-> ($stable(st.lockBit) && $stable(st.latch) && $stable(st.dpd));
    endproperty
    a_busy_no_change: assert property (p_busy_no_change) else $error("instruction obeyed while busy");

    property p_area_write;
        @(posedge clk) disable iff (!rstn)
        ($rose(st.busy) && (st.lastOp == `SFP_OP_PAGE_WR || st.lastOp == `SFP_OP_BLK_CLR))
            |-> !($past(st.areaHi) && $past(st.areaLo));
    endproperty
    a_area_write: assert property (p_area_write) else $error("write ran inside guarded area");

    property p_break_drop;
        @(posedge clk) disable iff (!rstn)
        ($past(clkEn) && $past(selRise) && $past(st.paused))
            |-> ($stable(st.latch) && $stable(st.lastOp) && st.bitCnt == 12'h000);
    endproperty
    a_break_drop: assert property (p_break_drop) else $error("frame obeyed after deselect in pause");

endmodule // sfp_flash_guard

// ### bench/sfp_host_model.sv
`timescale 1ns/1ps
`include "sfp_defs.svh"

module sfp_host_model
    import sfp_pkg::*;
(
    // clock
    input wire logic clk,
    // flash pins
    output sfp_pin_t pins,
    input wire logic misoOut,
    input wire logic misoOe
);
    logic lineLvl;
    logic lastLvl;
    logic [47:0] rxBits;
    int phase;
    // ==========================================================
    // released line shows a changing value, not a settled one
    assign lineLvl = misoOe ? misoOut : ~lastLvl;
    always @(posedge clk)
    begin
        lastLvl <= lineLvl;
    end
    initial
    begin
        pins = '{sck: 1'b0, selN: 1'b1, mosi: 1'b0, pauseN: 1'b1, protectN: 1'b1};
        lastLvl = 1'b0;
        rxBits = '0;
        phase = 0;
    end
    // ==========================================================
    // sck period 13 clk, nearest to 64 ns on the 5 ns grid
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic set_prot(input logic v);
        pins.protectN <= v;
        tick(8);
    endtask
    // pauseAt: bit after whose rise the pause starts, brk: deselect in pause
    task automatic xfer(input logic [47:0] bits, input int n, input int pauseAt, input bit brk);
        int i;
        pins.selN <= 1'b0;
        tick(7);
        for (i = 0; i < n; i++)
        begin
            pins.mosi <= bits[n-1-i];
            tick(6);
            pins.sck <= 1'b1;
            rxBits <= {rxBits[46:0], lineLvl};
            tick(7);
            if (i == pauseAt)
            begin
                // pause falls with sck high, so entry waits for sck low
                pins.pauseN <= 1'b0;
                phase <= 1;
                tick(12);
                pins.sck <= 1'b0;
                tick(7);
                phase <= 2;
                repeat (3)
                begin
                    pins.sck <= 1'b1;
                    pins.mosi <= ~pins.mosi;
                    tick(6);
                    pins.sck <= 1'b0;
                    tick(7);
                end
                if (brk)
                begin
                    pins.selN <= 1'b1;
                    tick(7);
                end
                pins.pauseN <= 1'b1;
                phase <= 0;
                tick(7);
                if (brk)
                    return;
            end
            pins.sck <= 1'b0;
        end
        tick(6);
        pins.selN <= 1'b1;
        tick(13);
    endtask
endmodule // sfp_host_model

// ### bench/spi_flash_hold_and_write_protect_tb_top.sv
`timescale 1ns/1ps
`include "sfp_defs.svh"

module spi_flash_hold_and_write_protect_tb_top
    import sfp_pkg::*;
;
    logic clk;
    logic rstn;
    logic clkEn;
    sfp_pin_t pinIn;
    logic misoOut;
    logic misoOe;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI;
    logic wbAck;
    logic [31:0] wbDatO;
    int bad_count;
    int n_compared;
    int i;
    logic [47:0] frm [2];
    int len [2];
    logic [3:0] selUse;

    sfp_flash_guard DUT (.clk(clk), .rstn(rstn), .clkEn(clkEn), .pinIn(pinIn), .misoOut(misoOut),
        .misoOe(misoOe), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatI(wbDatI), .wbAck(wbAck), .wbDatO(wbDatO));
    sfp_host_model host (.clk(clk), .pins(pinIn), .misoOut(misoOut), .misoOe(misoOe));

    // ==========================================================
    // wishbone, compare and frame tasks
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb_cyc(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        wbSel <= selUse;
        @(posedge clk);
        // only the watchdog ends a wait for ack
        while (wbAck !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_reg(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cyc(1'b0, adr, 32'h0, rd);
        chk(rd & mask, exp);
    endtask
    task automatic op8(input logic [7:0] op);
        host.xfer({40'h0, op}, 8, -1, 1'b0);
    endtask
    task automatic swr(input logic [7:0] d);
        host.xfer({32'h0, `SFP_OP_STAT_WR, d}, 16, -1, 1'b0);
    endtask

    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial
    begin
        logic [31:0] rd;
        rstn = 1'b0;
        clkEn = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        selUse = 4'hF;
        wbDatI = 32'h0;
        bad_count = 0;
        n_compared = 0;
        frm[0] = {40'h0, `SFP_OP_ALL_CLR};
        len[0] = 8;
        frm[1] = {16'h0, `SFP_OP_BLK_CLR, 24'h008000};
        len[1] = 32;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_reg(`SFP_ADR_CTRL, 32'hFFFFFFFF, 32'h1);
        // low byte lane off: supply write ignored
        selUse = 4'hE;
        wb_cyc(1'b1, `SFP_ADR_CTRL, 32'h0, rd);
        selUse = 4'hF;
        chk_reg(`SFP_ADR_CTRL, 32'hFFFFFFFF, 32'h1);
        chk_reg(`SFP_ADR_STAT, 32'h0FFF, 32'h0);
        wb_cyc(1'b1, 8'h0C, 32'hFF, rd);
        chk_reg(8'h0C, 32'hFFFFFFFF, 32'h0);
        // modifying frames before and after the power-up delay ends
        op8(`SFP_OP_UNLOCK);
        swr(8'h8C);
        chk_reg(`SFP_ADR_STAT, 32'h4FD, 32'h0);
        host.tick(2100);
        chk_reg(`SFP_ADR_STAT, 32'h400, 32'h400);
        op8(`SFP_OP_LOCK);
        chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h0);
        swr(8'h8C);
        chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h0);
        op8(`SFP_OP_UNLOCK);
        host.xfer({33'h0, `SFP_OP_STAT_WR, 7'h46}, 15, -1, 1'b0);
        chk_reg(`SFP_ADR_STAT, 32'hFD, 32'h0);
        op8(`SFP_OP_UNLOCK);
        swr(8'h8C);
        chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h8D);
        op8(`SFP_OP_UNLOCK);
        host.xfer({32'h0, `SFP_OP_STAT_RD, 8'h00}, 16, -1, 1'b0);
        chk({24'h0, host.rxBits[7:0]}, 32'h8D);
        host.tick(450);
        chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h8C);
        // protected area
        op8(`SFP_OP_UNLOCK);
        host.xfer({8'h0, `SFP_OP_PAGE_WR, 24'h001000, 8'h55}, 40, -1, 1'b0);
        chk_reg(`SFP_ADR_STAT, 32'hFD, 32'h8C);
        op8(`SFP_OP_UNLOCK);
        op8(`SFP_OP_ALL_CLR);
        chk_reg(`SFP_ADR_STAT, 32'hFD, 32'h8C);
        // hard guard entered by pin after lock bit
        host.set_prot(1'b0);
        chk_reg(`SFP_ADR_STAT, 32'h800, 32'h800);
        op8(`SFP_OP_UNLOCK);
        swr(8'h00);
        chk_reg(`SFP_ADR_STAT, 32'hFD, 32'h8C);
        host.set_prot(1'b1);
        chk_reg(`SFP_ADR_STAT, 32'h800, 32'h0);
        op8(`SFP_OP_UNLOCK);
        swr(8'h00);
        chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h01);
        host.tick(450);
        // hard guard entered by lock bit after pin
        host.set_prot(1'b0);
        op8(`SFP_OP_UNLOCK);
        swr(8'h80);
        host.tick(450);
        chk_reg(`SFP_ADR_STAT, 32'h8FF, 32'h880);
        host.set_prot(1'b1);
        for (i = 0; i < 2; i++)
        begin
            op8(`SFP_OP_UNLOCK);
            host.xfer(frm[i], len[i], -1, 1'b0);
            chk_reg(`SFP_ADR_STAT, 32'hFF, 32'h81);
            host.tick(450);
        end
        chk_reg(`SFP_ADR_LAST, 32'h3FF, 32'h1D8);
        // supply flag low blocks modifying frames
        wb_cyc(1'b1, `SFP_ADR_CTRL, 32'h0, rd);
        op8(`SFP_OP_UNLOCK);
        host.xfer(frm[1], 32, -1, 1'b0);
        chk_reg(`SFP_ADR_STAT, 32'hFD, 32'h80);
        chk_reg(`SFP_ADR_LAST, 32'h3FF, 32'h3D8);
        wb_cyc(1'b1, `SFP_ADR_CTRL, 32'h1, rd);
        // deep power-down
        op8(`SFP_OP_UNLOCK);
        op8(`SFP_OP_SLEEP);
        op8(`SFP_OP_LOCK);
        chk_reg(`SFP_ADR_STAT, 32'h202, 32'h202);
        op8(`SFP_OP_WAKE);
        chk_reg(`SFP_ADR_STAT, 32'h202, 32'h002);
        op8(`SFP_OP_LOCK);
        // pause in mid-opcode, garbage clocks while paused
        fork
            host.xfer({40'h0, `SFP_OP_UNLOCK}, 8, 3, 1'b0);
            begin
                wait (host.phase == 1);
                @(posedge clk);
                chk_reg(`SFP_ADR_STAT, 32'h100, 32'h0);
                wait (host.phase == 2);
                @(posedge clk);
                chk_reg(`SFP_ADR_STAT, 32'h100, 32'h100);
            end
        join
        chk_reg(`SFP_ADR_STAT, 32'h1FF, 32'h082);
        host.xfer({40'h0, `SFP_OP_LOCK}, 8, 3, 1'b1);
        chk_reg(`SFP_ADR_STAT, 32'h102, 32'h002);
        op8(`SFP_OP_LOCK);
        chk_reg(`SFP_ADR_STAT, 32'h002, 32'h0);
        // enable low: a whole frame goes unseen
        clkEn <= 1'b0;
        op8(`SFP_OP_UNLOCK);
        clkEn <= 1'b1;
        chk_reg(`SFP_ADR_STAT, 32'h002, 32'h0);
        // reset in mid-run clears latch, lock and delay
        op8(`SFP_OP_UNLOCK);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_reg(`SFP_ADR_STAT, 32'h482, 32'h0);
        end_sim();
    end
endmodule // spi_flash_hold_and_write_protect_tb_top
